/* src/scd_device.sv */
// device end: decodes configuration frames, soft reset, hold timers
// assumes link pins arrive asynchronously and are synchronised here
`timescale 1ns/1ns
module scd_device
   import scd_pkg::*;
#(
   parameter int HOLD_UNIT = scd_pkg::HOLD_UNIT_CYCLES
)(
   // clock and reset
   input  wire logic                      core_clk,
   input  wire logic                      rst_b,
   // link to the host
   scd_spi_if.dev                         spi,
   // fire enable inputs and stretched outputs
   input  wire logic [scd_pkg::FEN_N-1:0] fire_enable_input,
   output logic      [scd_pkg::FEN_N-1:0] fire_enable_hold,
   // stored settings and soft reset strobe
   output logic      [1:0]                deploy_current_code,
   output logic      [1:0]                fire_enable_hold_code,
   output logic                           soft_reset_pulse
);
   import scd_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // input synchronisers: stage 0 feeds stage 1 only
   logic [2:0]       sclk_sync_ff, nxt_sclk_sync;
   logic [2:0]       cs_sync_ff,   nxt_cs_sync;
   logic [1:0]       mosi_sync_ff, nxt_mosi_sync;
   logic [FEN_N-1:0] fen_s0_ff, nxt_fen_s0, fen_s1_ff, nxt_fen_s1;
   logic             sclk_rise, sclk_fall, cs_fall, cs_rise, in_frame;

   // shift each chain by one stage
   always_comb begin
      nxt_sclk_sync = {sclk_sync_ff[1:0], spi.sclk};
      nxt_cs_sync   = {cs_sync_ff[1:0], spi.cs_b};
      nxt_mosi_sync = {mosi_sync_ff[0], spi.mosi};
      nxt_fen_s0    = fire_enable_input;
      nxt_fen_s1    = fen_s0_ff;
   end

   // register the chains; cs idles high
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         sclk_sync_ff <= 3'h0;
         cs_sync_ff   <= 3'h7;
         mosi_sync_ff <= 2'h0;
         fen_s0_ff    <= '0;
         fen_s1_ff    <= '0;
      end else begin
         sclk_sync_ff <= nxt_sclk_sync;
         cs_sync_ff   <= nxt_cs_sync;
         mosi_sync_ff <= nxt_mosi_sync;
         fen_s0_ff    <= nxt_fen_s0;
         fen_s1_ff    <= nxt_fen_s1;
      end
   end

   // edges seen between stage 1 and stage 2
   assign sclk_rise = sclk_sync_ff[1] & ~sclk_sync_ff[2];
   assign sclk_fall = ~sclk_sync_ff[1] & sclk_sync_ff[2];
   assign cs_fall   = ~cs_sync_ff[1] & cs_sync_ff[2];
   assign cs_rise   = cs_sync_ff[1] & ~cs_sync_ff[2];
   assign in_frame  = ~cs_sync_ff[1];

   ////////////////////////////////////////////////////////////////////
   // frame engine and command decode
   logic [15:0] rx_ff,   nxt_rx;
   logic [15:0] tx_ff,   nxt_tx;
   logic [15:0] resp_ff, nxt_resp;
   logic [4:0]  bit_cnt_ff, nxt_bit_cnt;
   logic [1:0]  cl_ff,   nxt_cl;
   logic [1:0]  hold_ff, nxt_hold;
   logic        armed_ff, nxt_armed;
   logic        miso_ff, nxt_miso, miso_oe_ff, nxt_miso_oe;
   logic        srst_ff, nxt_srst;
   logic        wr, soft_reset_select;
   logic [7:0]  low_byte;

   assign wr       = rx_ff[BIT_RW];
   assign soft_reset_select      = rx_ff[BIT_SWR];
   assign low_byte = rx_ff[7:0];

   // shift bits in and out, decode on cs rising after 16 bits
   always_comb begin
      nxt_rx      = rx_ff;
      nxt_tx      = tx_ff;
      nxt_resp    = resp_ff;
      nxt_bit_cnt = bit_cnt_ff;
      nxt_cl      = cl_ff;
      nxt_hold    = hold_ff;
      nxt_armed   = armed_ff;
      nxt_miso    = miso_ff;
      nxt_miso_oe = miso_oe_ff;
      nxt_srst    = 1'b0;
      if (cs_fall) begin
         nxt_bit_cnt = 5'h0;
         nxt_tx      = resp_ff;
         nxt_miso    = resp_ff[FRAME_W-1];
         nxt_miso_oe = 1'b1;
      end
      if (in_frame && sclk_rise && bit_cnt_ff != FRAME_BITS) begin
         nxt_rx      = {rx_ff[14:0], mosi_sync_ff[1]};
         nxt_bit_cnt = bit_cnt_ff + 5'h1;
      end
      if (in_frame && sclk_fall) begin
         nxt_tx   = {tx_ff[14:0], 1'b0};
         nxt_miso = tx_ff[14];
      end
      if (cs_rise) begin
         nxt_miso_oe = 1'b0;
         nxt_armed   = 1'b0;
         if (bit_cnt_ff != FRAME_BITS) begin
            nxt_resp = resp_ff;
         end else if (!parity_ok(rx_ff)) begin
            nxt_resp = armed_ff ? RESP_FAULT_ARM : RESP_FAULT;
         end else if (rx_ff[BIT_MODE_HI:BIT_MODE_LO] != MODE_CONFIG) begin
            nxt_resp = with_odd_parity({rx_ff[BIT_MODE_HI:BIT_MODE_LO],
                                        14'h0});
         end else if (!rx_ff[BIT_VARIANT]) begin
            if (wr && !soft_reset_select) begin
               nxt_cl = rx_ff[BIT_CODE_HI:BIT_CODE_LO];
            end else if (wr && soft_reset_select) begin
               if (armed_ff && low_byte == SR_SECOND) begin
                  nxt_srst = 1'b1;
               end else if (low_byte == SR_FIRST) begin
                  nxt_armed = 1'b1;
               end
            end
            nxt_resp = with_odd_parity({MODE_CONFIG, 1'b0, wr, soft_reset_select, 1'b0,
                                    nxt_cl, LOW_CURRENT});
         end else begin
            if (wr && !soft_reset_select && low_byte == LOW_HOLD) begin
               nxt_hold = rx_ff[BIT_CODE_HI:BIT_CODE_LO];
            end
            nxt_resp = with_odd_parity({MODE_CONFIG, 1'b0, wr, 1'b0, 1'b1,
                                        nxt_hold, LOW_HOLD});
         end
         if (nxt_srst) begin
            nxt_cl    = CODE_DEFAULT;
            nxt_hold  = CODE_DEFAULT;
            nxt_armed = 1'b0;
            nxt_resp  = RESP_SOFT_RESET;
         end
      end
   end

   // frame engine registers
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_ff      <= 16'h0;
         tx_ff      <= 16'h0;
         resp_ff    <= RESP_RESET;
         bit_cnt_ff <= 5'h0;
         cl_ff      <= CODE_DEFAULT;
         hold_ff    <= CODE_DEFAULT;
         armed_ff   <= 1'b0;
         miso_ff    <= 1'b0;
         miso_oe_ff <= 1'b0;
         srst_ff    <= 1'b0;
      end else begin
         rx_ff      <= nxt_rx;
         tx_ff      <= nxt_tx;
         resp_ff    <= nxt_resp;
         bit_cnt_ff <= nxt_bit_cnt;
         cl_ff      <= nxt_cl;
         hold_ff    <= nxt_hold;
         armed_ff   <= nxt_armed;
         miso_ff    <= nxt_miso;
         miso_oe_ff <= nxt_miso_oe;
         srst_ff    <= nxt_srst;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pulse stretch timers, one per fire enable input

   // hold length in cycles for a code: 0, 1, 2 or 4 units
   function automatic logic [HOLD_CNT_W-1:0] hold_cycles(
      input logic [1:0] code);
      logic [HOLD_CNT_W-1:0] unit;
      unit = HOLD_CNT_W'(HOLD_UNIT);
      unique case (code)
         2'h0:    hold_cycles = '0;
         2'h1:    hold_cycles = unit;
         2'h2:    hold_cycles = unit << 1;
         default: hold_cycles = unit << 2;
      endcase
   endfunction

   genvar g;
   generate
      for (g = 0; g < FEN_N; g++) begin : gen_timer
         logic [HOLD_CNT_W-1:0] cnt_ff, nxt_cnt;
         logic                  prev_ff, nxt_prev;
         logic                  out_ff, nxt_out;

         // load on a rising input, count down, or clear on soft reset
         always_comb begin
            nxt_prev = fen_s1_ff[g];
            nxt_cnt  = cnt_ff;
            if (srst_ff) begin
               nxt_cnt  = '0;
               nxt_prev = 1'b0;
            end else if (fen_s1_ff[g] && !prev_ff) begin
               nxt_cnt = hold_cycles(hold_ff);
            end else if (cnt_ff != '0) begin
               nxt_cnt = cnt_ff - 1'b1;
            end
            nxt_out = !srst_ff && (fen_s1_ff[g] || nxt_cnt != '0);
         end

         // timer registers
         always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
               cnt_ff  <= '0;
               prev_ff <= 1'b0;
               out_ff  <= 1'b0;
            end else begin
               cnt_ff  <= nxt_cnt;
               prev_ff <= nxt_prev;
               out_ff  <= nxt_out;
            end
         end

         assign fire_enable_hold[g] = out_ff;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////
   // outputs straight from flops
   assign spi.miso              = miso_ff;
   assign spi.miso_oe           = miso_oe_ff;
   assign deploy_current_code   = cl_ff;
   assign fire_enable_hold_code = hold_ff;
   assign soft_reset_pulse      = srst_ff;

endmodule

/* src/scd_host.sv */
// host end: master of the link, sends commands and soft reset pairs
// assumes the device end answers on miso one frame later
`timescale 1ns/1ns
module scd_host
   import scd_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   // link to the device
   scd_spi_if.host          spi,
   // command request
   input  wire logic        cmd_valid,
   input  wire logic [15:0] cmd_word,
   output logic             cmd_ready,
   // soft reset request
   input  wire logic        soft_reset_req,
   // response from the previous frame
   output logic             resp_valid,
   output logic [15:0]      resp_word
);
   import scd_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SHIFT = 2'b01,
      ST_GAP   = 2'b10
   } scd_host_state_t;

   localparam logic [15:0] SR_HEAD  = 16'h1800; // write, select set
   localparam logic [4:0]  HALF_MAX = 5'(SCLK_HALF_CYCLES - 1);
   localparam logic [4:0]  GAP_MAX  = 5'(FRAME_GAP_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////
   // miso synchroniser
   logic [1:0] miso_sync_ff, nxt_miso_sync;

   // shift the chain
   always_comb begin
      nxt_miso_sync = {miso_sync_ff[0], spi.miso_wire};
   end

   // register the chain
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         miso_sync_ff <= 2'h3;
      end else begin
         miso_sync_ff <= nxt_miso_sync;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // frame sequencer
   scd_host_state_t state_ff, nxt_state;
   logic [4:0]  cnt_ff,  nxt_cnt;
   logic [4:0]  bit_ff,  nxt_bit;
   logic [15:0] tx_ff,   nxt_tx;
   logic [15:0] rx_ff,   nxt_rx;
   logic [15:0] resp_ff, nxt_resp;
   logic        sclk_ff, nxt_sclk, cs_b_ff, nxt_cs_b, mosi_ff, nxt_mosi;
   logic        ready_ff, nxt_ready, valid_ff, nxt_valid;
   logic        sr_pend_ff, nxt_sr_pend;
   logic [15:0] start_word;
   logic        start;

   // pick the next frame: second reset byte, new reset, or command
   always_comb begin
      start      = 1'b1;
      start_word = with_odd_parity(cmd_word);
      if (sr_pend_ff) begin
         start_word = with_odd_parity({SR_HEAD[15:8], SR_SECOND});
      end else if (soft_reset_req) begin
         start_word = with_odd_parity({SR_HEAD[15:8], SR_FIRST});
      end else if (!cmd_valid) begin
         start = 1'b0;
      end
   end

   // walk idle, shift and gap
   always_comb begin
      nxt_state   = state_ff;
      nxt_cnt     = cnt_ff;
      nxt_bit     = bit_ff;
      nxt_tx      = tx_ff;
      nxt_rx      = rx_ff;
      nxt_resp    = resp_ff;
      nxt_sclk    = sclk_ff;
      nxt_cs_b    = cs_b_ff;
      nxt_mosi    = mosi_ff;
      nxt_ready   = ready_ff;
      nxt_valid   = 1'b0;
      nxt_sr_pend = sr_pend_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (start) begin
               nxt_state   = ST_SHIFT;
               nxt_tx      = start_word;
               nxt_mosi    = start_word[FRAME_W-1];
               nxt_cs_b    = 1'b0;
               nxt_cnt     = 5'h0;
               nxt_bit     = 5'h0;
               nxt_ready   = 1'b0;
               // first byte leaves the second pending, sent after the frame gap with no command between
               nxt_sr_pend = !sr_pend_ff && soft_reset_req;
            end
         end
         ST_SHIFT: begin
            if (cnt_ff == HALF_MAX) begin
               nxt_cnt = 5'h0;
               if (!sclk_ff) begin
                  nxt_sclk = 1'b1;
                  nxt_rx   = {rx_ff[14:0], miso_sync_ff[1]};
                  nxt_bit  = bit_ff + 5'h1;
               end else begin
                  nxt_sclk = 1'b0;
                  if (bit_ff == FRAME_BITS) begin
                     nxt_cs_b  = 1'b1;
                     nxt_state = ST_GAP;
                     nxt_valid = 1'b1;
                     nxt_resp  = rx_ff;
                  end else begin
                     nxt_tx   = {tx_ff[14:0], 1'b0};
                     nxt_mosi = tx_ff[14];
                  end
               end
            end else begin
               nxt_cnt = cnt_ff + 5'h1;
            end
         end
         ST_GAP: begin
            if (cnt_ff == GAP_MAX) begin
               nxt_state = ST_IDLE;
               nxt_cnt   = 5'h0;
               nxt_ready = !sr_pend_ff;
            end else begin
               nxt_cnt = cnt_ff + 5'h1;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
            nxt_cs_b  = 1'b1;
            nxt_sclk  = 1'b0;
         end
      endcase
   end

   // sequencer registers
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff   <= ST_IDLE;
         cnt_ff     <= 5'h0;
         bit_ff     <= 5'h0;
         tx_ff      <= 16'h0;
         rx_ff      <= 16'h0;
         resp_ff    <= 16'h0;
         sclk_ff    <= 1'b0;
         cs_b_ff    <= 1'b1;
         mosi_ff    <= 1'b0;
         ready_ff   <= 1'b1;
         valid_ff   <= 1'b0;
         sr_pend_ff <= 1'b0;
      end else begin
         state_ff   <= nxt_state;
         cnt_ff     <= nxt_cnt;
         bit_ff     <= nxt_bit;
         tx_ff      <= nxt_tx;
         rx_ff      <= nxt_rx;
         resp_ff    <= nxt_resp;
         sclk_ff    <= nxt_sclk;
         cs_b_ff    <= nxt_cs_b;
         mosi_ff    <= nxt_mosi;
         ready_ff   <= nxt_ready;
         valid_ff   <= nxt_valid;
         sr_pend_ff <= nxt_sr_pend;
      end
   end

   // outputs straight from flops
   assign spi.sclk   = sclk_ff;
   assign spi.cs_b   = cs_b_ff;
   assign spi.mosi   = mosi_ff;
   assign cmd_ready  = ready_ff;
   assign resp_valid = valid_ff;
   assign resp_word  = resp_ff;

endmodule

/* src/scd_pkg.sv */
// constants, frame fields and parity helpers of the config decoder link
// assumes a 10 MHz core clock on both ends of the link
package scd_pkg;

   ////////////////////////////////////////////////////////////////////
   // frame layout
   localparam int          FRAME_W      = 16;
   localparam int          BIT_PARITY   = 13;
   localparam int          BIT_RW       = 12;
   localparam int          BIT_SWR      = 11;
   localparam int          BIT_VARIANT  = 10;
   localparam int          BIT_CODE_HI  = 9;
   localparam int          BIT_CODE_LO  = 8;
   localparam int          BIT_MODE_HI  = 15;
   localparam int          BIT_MODE_LO  = 14;
   localparam logic [1:0]  MODE_CONFIG  = 2'h0;
   localparam logic [4:0]  FRAME_BITS   = 5'h10;

   ////////////////////////////////////////////////////////////////////
   // soft reset bytes, codes and fixed response words
   localparam logic [7:0]  SR_FIRST        = 8'hAA;
   localparam logic [7:0]  SR_SECOND       = 8'h55;
   localparam logic [1:0]  CODE_DEFAULT    = 2'h0;
   localparam logic [7:0]  LOW_CURRENT     = 8'h02;
   localparam logic [7:0]  LOW_HOLD        = 8'h00;
   localparam logic [15:0] RESP_RESET      = 16'h2000;
   localparam logic [15:0] RESP_SOFT_RESET = 16'h2003;
   localparam logic [15:0] RESP_FAULT      = 16'hD000;
   localparam logic [15:0] RESP_FAULT_ARM  = 16'hD003;

   ////////////////////////////////////////////////////////////////////
   // timing
   localparam int CLK_PERIOD_NS    = 100;
   localparam int CLK_KHZ          = 10000;
   localparam int HOLD_UNIT_MS     = 128;
   localparam int HOLD_UNIT_CYCLES = HOLD_UNIT_MS * CLK_KHZ;
   localparam int HOLD_CNT_W       = 24;
   localparam int SCLK_HALF_NS     = 800;
   localparam int SCLK_HALF_CYCLES = SCLK_HALF_NS / CLK_PERIOD_NS;
   localparam int FRAME_GAP_NS     = 1600;
   localparam int FRAME_GAP_CYCLES = FRAME_GAP_NS / CLK_PERIOD_NS;
   localparam int FEN_N            = 4;

   ////////////////////////////////////////////////////////////////////
   // parity helpers: whole word must hold an odd count of ones
   function automatic logic [15:0] with_odd_parity(input logic [15:0] w);
      logic [15:0] t;
      t             = w;
      t[BIT_PARITY] = 1'b0;
      t[BIT_PARITY] = ~(^t);
      return t;
   endfunction

   function automatic logic parity_ok(input logic [15:0] w);
      return ^w;
   endfunction

endpackage

/* src/scd_spi_if.sv */
// four-wire serial link between the host end and the device end
// assumes both ends run on their own core clock; miso idles high
`timescale 1ns/1ns
interface scd_spi_if;
   logic sclk;
   logic cs_b;
   logic mosi;
   logic miso;
   logic miso_oe;
   logic miso_wire;

   // miso line level worked out from the device's enable
   assign miso_wire = miso_oe ? miso : 1'b1;

   modport dev  (input sclk, input cs_b, input mosi,
                 output miso, output miso_oe);
   modport host (output sclk, output cs_b, output mosi,
                 input miso_wire);
endinterface

/* verification/scd_assertions.sv */
// checker on the link between host and device ends
// assumes the bench wires it to the link signals by name
`timescale 1ns/1ns
module scd_assertions (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // link signals
   input wire logic sclk,
   input wire logic cs_b,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe
);
   logic [4:0]  bits_ff;
   logic [15:0] mosi_sr_ff;
   logic [15:0] miso_sr_ff;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   ////////////////////////////////////////////////////////////////////
   // count bits and shift both data lines on each link clock rise
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         bits_ff    <= 5'h00;
         mosi_sr_ff <= 16'h0000;
         miso_sr_ff <= 16'h0000;
      end else if ($fell(cs_b)) begin
         bits_ff <= 5'h00;
      end else if ($rose(sclk)) begin
         bits_ff    <= bits_ff + 5'h01;
         mosi_sr_ff <= {mosi_sr_ff[14:0], mosi};
         miso_sr_ff <= {miso_sr_ff[14:0], miso};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // link clock phases within a frame
   sequence clk_high;
      sclk [*8] ##1 !sclk;
   endsequence
   sequence clk_lead;
      !sclk [*8] ##1 sclk;
   endsequence

   idle_clock_low_a : assert property (cs_b |-> !sclk)
      else $error("link clock moves outside a frame");
   frame_lead_in_a : assert property ($fell(cs_b) |-> clk_lead)
      else $error("first clock rise misplaced");
   clock_high_time_a : assert property ($rose(sclk) |-> clk_high)
      else $error("clock high phase wrong length");
   frame_bit_count_a : assert property
      ($rose(cs_b) |-> bits_ff == 5'h10 && $past(sclk))
      else $error("frame does not hold sixteen bits");
   frame_gap_a : assert property
      ($rose(cs_b) |-> cs_b [*8] ##1 cs_b [*8])
      else $error("gap between frames too short");
   mosi_parity_a : assert property ($rose(cs_b) |-> ^mosi_sr_ff)
      else $error("command word parity even");
   miso_parity_a : assert property ($rose(cs_b) |-> ^miso_sr_ff)
      else $error("response word parity even");
   mosi_stable_a : assert property (sclk |-> $stable(mosi))
      else $error("command bit moves while clock high");
   miso_stable_a : assert property (sclk |-> $stable(miso))
      else $error("response bit moves while clock high");
   miso_drive_a : assert property ($fell(cs_b) |-> ##[1:5] miso_oe)
      else $error("response line not driven in frame");
   miso_release_a : assert property
      ($rose(cs_b) |-> ##[1:5] !miso_oe)
      else $error("response line not released");
endmodule

/* verification/tb_squib_config_command_decoder.sv */
// bench joining host end and device end over the link
// assumes design package, interface and both ends compiled first
`timescale 1ns/1ns
module tb_squib_config_command_decoder;
   logic        core_clk;
   logic        rst_b;
   logic        cmd_valid;
   logic [15:0] cmd_word;
   logic        cmd_ready;
   logic        soft_reset_req;
   logic        resp_valid;
   logic [15:0] resp_word;
   logic [3:0]  fire_enable_input;
   logic [3:0]  fire_enable_hold;
   logic [1:0]  deploy_current_code;
   logic [1:0]  fire_enable_hold_code;
   logic        soft_reset_pulse;
   logic        srp_seen;
   int          failures;
   int          n_compared;

   scd_spi_if spi_link ();
   scd_host u_scd_host (.core_clk(core_clk), .rst_b(rst_b),
      .spi(spi_link.host), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
      .cmd_ready(cmd_ready), .soft_reset_req(soft_reset_req),
      .resp_valid(resp_valid), .resp_word(resp_word));
   scd_device #(.HOLD_UNIT(20)) u_scd_device (.core_clk(core_clk),
      .rst_b(rst_b), .spi(spi_link.dev),
      .fire_enable_input(fire_enable_input),
      .fire_enable_hold(fire_enable_hold),
      .deploy_current_code(deploy_current_code),
      .fire_enable_hold_code(fire_enable_hold_code),
      .soft_reset_pulse(soft_reset_pulse));
   scd_assertions u_scd_assertions (.core_clk(core_clk), .rst_b(rst_b),
      .sclk(spi_link.sclk), .cs_b(spi_link.cs_b), .mosi(spi_link.mosi),
      .miso(spi_link.miso), .miso_oe(spi_link.miso_oe));

   ////////////////////////////////////////////////////////////////////
   // clock and sticky soft reset flag
   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (soft_reset_pulse === 1'b1) srp_seen = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////
   // shared helpers
   function automatic logic [15:0] op(input logic [15:0] w);
      w[13] = 1'b0;
      w[13] = ~(^w);
      return w;
   endfunction

   task automatic final_report();
      if (failures == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   task automatic bound(input int k);
      if (k >= 400) begin
         failures++;
         $display("wrong value at %0t: wait timed out", $time);
         final_report();
      end
   endtask

   task automatic wait_resp(output logic [15:0] r);
      int k;
      k = 0;
      while (resp_valid !== 1'b1 && k < 400) begin
         tick(1);
         k++;
      end
      bound(k);
      r = resp_word;
      tick(8);
   endtask

   // one command or soft reset request, returns previous answer
   task automatic xfer(input logic [15:0] w, input bit sr,
                       output logic [15:0] r);
      int k;
      k = 0;
      while (cmd_ready !== 1'b1 && k < 400) begin
         tick(1);
         k++;
      end
      bound(k);
      cmd_word = w;
      cmd_valid = !sr;
      soft_reset_req = sr;
      tick(1);
      cmd_valid = 1'b0;
      soft_reset_req = 1'b0;
      wait_resp(r);
   endtask

   ////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_power_up();
      logic [15:0] r;
      chk({14'h0, deploy_current_code}, 16'h0000);
      chk({14'h0, fire_enable_hold_code}, 16'h0000);
      xfer(16'h0000, 1'b0, r);
      chk(r, 16'h2000);
      xfer(16'h0400, 1'b0, r);
      chk(r, op(16'h0002));
   endtask

   task automatic t_codes();
      logic [15:0] r;
      logic [15:0] e;
      logic [1:0]  c;
      e = op(16'h0400);
      for (int i = 0; i < 4; i++) begin
         c = 2'(3 - i);
         xfer(op({6'h04, c, 8'h5A}), 1'b0, r);
         chk(r, e);
         chk({14'h0, deploy_current_code}, {14'h0, c});
         xfer(op({6'h05, ~c, 8'h00}), 1'b0, r);
         chk(r, op({6'h04, c, 8'h02}));
         chk({14'h0, fire_enable_hold_code}, {14'h0, ~c});
         e = op({6'h05, ~c, 8'h00});
      end
      xfer(op(16'h0FFF), 1'b0, r);
      xfer(op(16'h0BFF), 1'b0, r);
      chk(r, op(16'h0700));
      chk({14'h0, deploy_current_code}, 16'h0000);
      chk({14'h0, fire_enable_hold_code}, 16'h0003);
   endtask

   // each hold code on its own channel, others must stay quiet
   task automatic t_timer();
      logic [15:0] r;
      int          m;
      for (int c = 0; c < 4; c++) begin
         m = (c == 3) ? 4 : c;
         xfer(op({6'h05, 2'(c), 8'h00}), 1'b0, r);
         fire_enable_input = 4'(1 << c);
         tick(4);
         fire_enable_input = 4'h0;
         if (m > 0) begin
            tick(20 * m - 6);
            chk({12'h0, fire_enable_hold}, 16'(1 << c));
            tick(16);
         end else begin
            tick(10);
         end
         chk({12'h0, fire_enable_hold}, 16'h0000);
      end
   endtask

   task automatic t_soft_reset();
      logic [15:0] r;
      xfer(op(16'h1300), 1'b0, r);
      xfer(op(16'h1600), 1'b0, r);
      srp_seen = 1'b0;
      xfer(op(16'h18AA), 1'b0, r);
      chk(r, op(16'h1600));
      xfer(op(16'h1855), 1'b0, r);
      chk(r, op(16'h1B02));
      chk({15'h0, srp_seen}, 16'h0001);
      chk({12'h0,deploy_current_code,fire_enable_hold_code}, 16'h0);
      xfer(16'h0000, 1'b0, r);
      chk(r, 16'h2003);
      xfer(16'h0000, 1'b0, r);
      chk(r, op(16'h0002));
      xfer(op(16'h1100), 1'b0, r);
      srp_seen = 1'b0;
      xfer(16'h0000, 1'b1, r);
      wait_resp(r);
      chk(r, op(16'h1902));
      chk({15'h0, srp_seen}, 16'h0001);
      chk({14'h0, deploy_current_code}, 16'h0000);
   endtask

   // interrupted or out-of-order pairs must not reset anything
   task automatic t_broken();
      logic [15:0] r;
      logic [15:0] seq [7] = '{16'h1855, 16'h18AA, 16'h5300, 16'h1855,
                               16'h18AA, 16'h0000, 16'h1855};
      xfer(op(16'h1200), 1'b0, r);
      srp_seen = 1'b0;
      foreach (seq[i]) begin
         xfer(op(seq[i]), 1'b0, r);
      end
      chk({15'h0, srp_seen}, 16'h0000);
      chk({14'h0, deploy_current_code}, 16'h0002);
   endtask

   // mid-run reset brings codes and the power-up flag back
   task automatic t_reset();
      logic [15:0] r;
      xfer(op(16'h1600), 1'b0, r);
      chk({14'h0, fire_enable_hold_code}, 16'h0002);
      rst_b = 1'b0;
      tick(4);
      rst_b = 1'b1;
      tick(3);
      chk({12'h0,deploy_current_code,fire_enable_hold_code}, 16'h0);
      xfer(16'h0000, 1'b0, r);
      chk(r, 16'h2000);
   endtask

   ////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      core_clk = 1'b0;
      rst_b = 1'b0;
      cmd_valid = 1'b0;
      cmd_word = 16'h0000;
      soft_reset_req = 1'b0;
      fire_enable_input = 4'h0;
      srp_seen = 1'b0;
      failures = 0;
      n_compared = 0;
      tick(4);
      rst_b = 1'b1;
      tick(3);
      t_power_up();
      t_codes();
      t_timer();
      t_soft_reset();
      t_broken();
      t_reset();
      final_report();
   end
endmodule
